// *** uer_register_map.sv ***
// Summary of operation
// RL1: divisor latches at 000/001 when divisor bank open
// RL2: zero divisors read back revision and identity
// RL3: key bank address 000: trigger write, level read
// RL4: key bank: feature control 001, enhanced function 010
// RL5: key bank: flow characters at 100 to 111
// RL6: feature control field layout, bit 7 down
// RL7: enhanced function field layout, bit 7 down
// RL8: enhanced bits act only when unlock set
// RL9: summary select low returns ready summary
// RL10: interrupt mask gates four sources into status
// RL11: fifo and rx enabled show rx status
// RL12: rx interrupt when level reaches trigger
// RL13: rx status clears when level below trigger
// RL14: data ready set on load, cleared empty
// RL15: writes to read-only locations change nothing
`timescale 1ns/100ps
`default_nettype none
`include "uer_defs.svh"

module uer_register_map
  import uer_pkg::*;
#(
  parameter logic [7:0] REVISION = `UER_REVISION_DEFAULT,
  parameter logic [7:0] DEVICE_ID = `UER_DEVICE_ID_DEFAULT
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic summary_select_n_i,
  input wire logic [3:0] receive_ready_n_i,
  input wire logic [3:0] transmit_ready_n_i,
  input wire logic [7:0] receive_holding_i,
  input wire logic [7:0] rx_fifo_level_i,
  input wire logic rx_char_loaded_i,
  input wire logic [6:0] line_status_upper_i,
  input wire logic line_error_i,
  input wire logic tx_empty_i,
  input wire logic [7:0] modem_status_i,
  input wire logic modem_delta_i,
  input wire logic [1:0] enh_status_i,
  output logic [7:0] rdata_o,
  output logic rx_read_o,
  output logic tx_write_o,
  output logic [7:0] tx_data_o,
  output logic rx_fifo_reset_o,
  output logic tx_fifo_reset_o,
  output logic [15:0] divisor_o,
  output logic [7:0] line_control_o,
  output logic [7:0] interrupt_mask_o,
  output logic [7:0] fifo_control_o,
  output logic [7:0] modem_control_o,
  output logic [7:0] feature_control_o,
  output logic [7:0] enhanced_function_o,
  output logic [7:0] trigger_level_o,
  output logic [7:0] resume_char_first_o,
  output logic [7:0] resume_char_second_o,
  output logic [7:0] pause_char_first_o,
  output logic [7:0] pause_char_second_o,
  output logic [7:0] interrupt_status_o,
  output logic data_ready_o,
  output logic int_o
);

  // stored registers; several double as outputs
  logic [7:0] line_control_reg;
  logic [7:0] mask_raw_reg; // as written, before unlock gating
  logic [7:0] fifo_raw_reg;
  logic [7:0] modem_raw_reg;
  logic [7:0] scratch_reg;
  logic sum_sel_n; // synchronised summary select
  uer_bank_t bank;
  logic div_zero;
  logic unlock;
  logic fifo_en;
  logic rx_avail;
  logic [7:0] isr_next;
  logic [7:0] rdata_next;

  // the select pin comes from outside the clock domain
  uer_pin_sync #(
    .RESET_LEVEL(`UER_RST_SUMSEL)
  ) u_sum_sync (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .pin_i(summary_select_n_i),
    .level_o(sum_sel_n)
  );

  // bank selection from line control; the key value outranks bit 7
  always_comb begin
    if (line_control_reg == `UER_LCR_KEY) begin
      bank = UER_BANK_ENH;
    end else if (line_control_reg[`UER_LCR_DIV_BIT]) begin
      bank = UER_BANK_DIV; // RL1
    end else begin
      bank = UER_BANK_STD;
    end
  end

  assign div_zero = (divisor_o == 16'h0000);
  assign unlock = enhanced_function_o[`UER_EFR_UNLOCK_BIT];
  assign fifo_en = fifo_raw_reg[`UER_FCR_ENABLE_BIT];

  // divisor latches; writes land even when identity reads are showing
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      divisor_o <= 16'h0000;
    end else if (wr_i && bank == UER_BANK_DIV) begin
      if (addr_i == `UER_ADDR_0) begin
        divisor_o[7:0] <= wdata_i; // RL1
      end else if (addr_i == `UER_ADDR_1) begin
        divisor_o[15:8] <= wdata_i; // RL1
      end
    end
  end

  // line control is reachable from every bank so software can leave one
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      line_control_reg <= `UER_RST_ZERO;
    end else if (wr_i && addr_i == `UER_ADDR_3) begin
      line_control_reg <= wdata_i;
    end
  end

  // enhanced bank: trigger, feature, enhanced function, flow characters
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      trigger_level_o <= `UER_RST_ZERO;
      feature_control_o <= `UER_RST_ZERO;
      enhanced_function_o <= `UER_RST_ZERO;
      resume_char_first_o <= `UER_RST_ZERO;
      resume_char_second_o <= `UER_RST_ZERO;
      pause_char_first_o <= `UER_RST_ZERO;
      pause_char_second_o <= `UER_RST_ZERO;
    end else if (wr_i && bank == UER_BANK_ENH) begin
      unique case (addr_i)
        `UER_ADDR_0: trigger_level_o <= wdata_i; // RL3
        `UER_ADDR_1: feature_control_o <= wdata_i; // RL4 RL6
        `UER_ADDR_2: enhanced_function_o <= wdata_i; // RL4 RL7
        `UER_ADDR_4: resume_char_first_o <= wdata_i; // RL5
        `UER_ADDR_5: resume_char_second_o <= wdata_i; // RL5
        `UER_ADDR_6: pause_char_first_o <= wdata_i; // RL5
        `UER_ADDR_7: pause_char_second_o <= wdata_i; // RL5
        default: begin
          // line control is handled on its own
        end
      endcase
    end
  end

  // standard bank writes; status addresses 101 and 110 are read-only
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      mask_raw_reg <= `UER_RST_ZERO;
      fifo_raw_reg <= `UER_RST_ZERO;
      modem_raw_reg <= `UER_RST_ZERO;
      scratch_reg <= `UER_RST_ZERO;
    end else if (wr_i && bank == UER_BANK_STD) begin // RL15
      if (addr_i == `UER_ADDR_1) begin
        mask_raw_reg <= wdata_i;
      end
      if (addr_i == `UER_ADDR_2) begin
        // other bits take only with the enable bit set; resets self-clear
        fifo_raw_reg <= wdata_i[`UER_FCR_ENABLE_BIT] ?
          (wdata_i & 8'hf9) : 8'h00;
      end
      if (addr_i == `UER_ADDR_4) begin
        modem_raw_reg <= wdata_i;
      end
      if (addr_i == `UER_ADDR_7) begin
        scratch_reg <= wdata_i;
      end
    end
  end

  // one-cycle strobes toward the data path
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      tx_write_o <= 1'b0;
      tx_data_o <= `UER_RST_ZERO;
      rx_read_o <= 1'b0;
      rx_fifo_reset_o <= 1'b0;
      tx_fifo_reset_o <= 1'b0;
    end else begin
      tx_write_o <= wr_i && bank == UER_BANK_STD && addr_i == `UER_ADDR_0;
      if (wr_i && bank == UER_BANK_STD && addr_i == `UER_ADDR_0) begin
        tx_data_o <= wdata_i;
      end
      rx_read_o <= rd_i && sum_sel_n && bank == UER_BANK_STD &&
        addr_i == `UER_ADDR_0;
      rx_fifo_reset_o <= wr_i && bank == UER_BANK_STD &&
        addr_i == `UER_ADDR_2 && wdata_i[`UER_FCR_ENABLE_BIT] &&
        wdata_i[`UER_FCR_RX_RST_BIT];
      tx_fifo_reset_o <= wr_i && bank == UER_BANK_STD &&
        addr_i == `UER_ADDR_2 && wdata_i[`UER_FCR_ENABLE_BIT] &&
        wdata_i[`UER_FCR_TX_RST_BIT];
    end
  end

  // effective copies: locked enhanced bits read and act as zero
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      line_control_o <= `UER_RST_ZERO;
      interrupt_mask_o <= `UER_RST_ZERO;
      fifo_control_o <= `UER_RST_ZERO;
      modem_control_o <= `UER_RST_ZERO;
    end else begin
      line_control_o <= line_control_reg;
      interrupt_mask_o <= unlock ? mask_raw_reg :
        (mask_raw_reg & `UER_IER_BASE_MASK); // RL8
      fifo_control_o <= unlock ? fifo_raw_reg :
        (fifo_raw_reg & `UER_FCR_BASE_MASK); // RL8
      modem_control_o <= unlock ? modem_raw_reg :
        (modem_raw_reg & `UER_MCR_BASE_MASK); // RL8
    end
  end

  // receive data available: trigger compare in fifo mode, any byte otherwise
  assign rx_avail = fifo_en ?
    (rx_fifo_level_i != 8'h00 && rx_fifo_level_i >= trigger_level_o) :
    (rx_fifo_level_i != 8'h00); // RL12 RL13

  // status priority: line error, rx data, tx ready, modem change
  always_comb begin
    isr_next = {fifo_en, fifo_en, 2'b00, `UER_ISR_NONE};
    if (interrupt_mask_o[`UER_IER_LS_BIT] && line_error_i) begin
      isr_next[3:0] = `UER_ISR_LINE; // RL10
    end else if (interrupt_mask_o[`UER_IER_RX_BIT] && rx_avail) begin
      isr_next[3:0] = `UER_ISR_RECEIVE_READY_N; // RL11 RL12
    end else if (interrupt_mask_o[`UER_IER_TX_BIT] && tx_empty_i) begin
      isr_next[3:0] = `UER_ISR_TRANSMIT_READY_N; // RL10
    end else if (interrupt_mask_o[`UER_IER_MS_BIT] && modem_delta_i) begin
      isr_next[3:0] = `UER_ISR_MODEM; // RL10
    end
    if (unlock) begin
      isr_next[5:4] = enh_status_i; // RL8
    end
  end

  // status and interrupt pin follow the sources live, so they drop once
  // the level falls below the trigger without any read
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      interrupt_status_o <= `UER_RST_ISR;
      int_o <= 1'b0;
    end else begin
      interrupt_status_o <= isr_next; // RL13
      int_o <= (isr_next[3:0] != `UER_ISR_NONE); // RL13
    end
  end

  // data ready: a load in the same cycle as emptying wins
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      data_ready_o <= 1'b0;
    end else if (rx_char_loaded_i) begin
      data_ready_o <= 1'b1; // RL14
    end else if (rx_fifo_level_i == 8'h00) begin
      data_ready_o <= 1'b0; // RL14
    end
  end

  // read multiplexer; the summary select outranks every address
  always_comb begin
    unique case (addr_i)
      `UER_ADDR_0: rdata_next = receive_holding_i;
      `UER_ADDR_1: rdata_next = interrupt_mask_o;
      `UER_ADDR_2: rdata_next = interrupt_status_o;
      `UER_ADDR_3: rdata_next = line_control_reg;
      `UER_ADDR_4: rdata_next = modem_control_o;
      `UER_ADDR_5: rdata_next = {line_status_upper_i, data_ready_o};
      `UER_ADDR_6: rdata_next = modem_status_i;
      `UER_ADDR_7: rdata_next = scratch_reg;
    endcase
    if (bank == UER_BANK_DIV) begin
      if (addr_i == `UER_ADDR_0) begin
        rdata_next = div_zero ? REVISION : divisor_o[7:0]; // RL1 RL2
      end else if (addr_i == `UER_ADDR_1) begin
        rdata_next = div_zero ? DEVICE_ID : divisor_o[15:8]; // RL1 RL2
      end
    end else if (bank == UER_BANK_ENH) begin
      unique case (addr_i)
        `UER_ADDR_0: rdata_next = rx_fifo_level_i; // RL3
        `UER_ADDR_1: rdata_next = feature_control_o; // RL4
        `UER_ADDR_2: rdata_next = enhanced_function_o; // RL4
        `UER_ADDR_3: rdata_next = line_control_reg;
        `UER_ADDR_4: rdata_next = resume_char_first_o; // RL5
        `UER_ADDR_5: rdata_next = resume_char_second_o; // RL5
        `UER_ADDR_6: rdata_next = pause_char_first_o; // RL5
        `UER_ADDR_7: rdata_next = pause_char_second_o; // RL5
      endcase
    end
    if (!sum_sel_n) begin
      rdata_next = {receive_ready_n_i, transmit_ready_n_i}; // RL9
    end
  end

  // read data is held until the next read strobe
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      rdata_o <= `UER_RST_ZERO;
    end else if (rd_i) begin
      rdata_o <= rdata_next;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  a_div_low_write: assert property ( // RL1
    wr_i && bank == UER_BANK_DIV && addr_i == `UER_ADDR_0
    |=> divisor_o[7:0] == $past(wdata_i))
    else $error("divisor low latch missed a write");

  a_ident_read: assert property ( // RL2
    rd_i && sum_sel_n && bank == UER_BANK_DIV && div_zero &&
    addr_i == `UER_ADDR_1 |=> rdata_o == DEVICE_ID)
    else $error("identity not returned with zero divisor");

  a_level_read: assert property ( // RL3
    rd_i && sum_sel_n && bank == UER_BANK_ENH && addr_i == `UER_ADDR_0
    |=> rdata_o == $past(rx_fifo_level_i))
    else $error("level count not returned in key bank");

  a_efr_write: assert property ( // RL4
    wr_i && bank == UER_BANK_ENH && addr_i == `UER_ADDR_2
    |=> enhanced_function_o == $past(wdata_i))
    else $error("enhanced function write lost");

  a_flow_char_hold: assert property ( // RL5
    !(wr_i && bank == UER_BANK_ENH) |=> $stable(pause_char_second_o))
    else $error("flow character changed without key bank write");

  a_lock_gates_mask: assert property ( // RL8
    !unlock ##1 !unlock |-> interrupt_mask_o[7:4] == 4'h0)
    else $error("locked mask bits not zero");

  a_summary_read: assert property ( // RL9
    rd_i && !sum_sel_n
    |=> rdata_o == $past({receive_ready_n_i, transmit_ready_n_i}))
    else $error("ready summary not returned");

  a_rx_int_clear: assert property ( // RL13
    fifo_en && !line_error_i && rx_fifo_level_i < trigger_level_o &&
    !(interrupt_mask_o[`UER_IER_TX_BIT] && tx_empty_i) &&
    !(interrupt_mask_o[`UER_IER_MS_BIT] && modem_delta_i)
    |=> !int_o)
    else $error("interrupt held below trigger");

  a_ready_set_wins: assert property ( // RL14
    rx_char_loaded_i |=> data_ready_o)
    else $error("data ready not set on load");

  a_ro_write_inert: assert property ( // RL15
    wr_i && bank == UER_BANK_STD && addr_i == `UER_ADDR_5
    |=> $stable(mask_raw_reg) && $stable(scratch_reg) &&
        $stable(divisor_o))
    else $error("read-only write disturbed state");

endmodule : uer_register_map

`default_nettype wire

// *** uer_defs.svh ***
`ifndef UER_DEFS_SVH
`define UER_DEFS_SVH

// register addresses on the three address lines
`define UER_ADDR_0 3'h0
`define UER_ADDR_1 3'h1
`define UER_ADDR_2 3'h2
`define UER_ADDR_3 3'h3
`define UER_ADDR_4 3'h4
`define UER_ADDR_5 3'h5
`define UER_ADDR_6 3'h6
`define UER_ADDR_7 3'h7

// line control value that opens the enhanced bank
`define UER_LCR_KEY 8'hbf
// line control bit that opens the divisor bank
`define UER_LCR_DIV_BIT 7
// enhanced function bit that unlocks the enhanced bits
`define UER_EFR_UNLOCK_BIT 4
// fifo control bits
`define UER_FCR_ENABLE_BIT 0
`define UER_FCR_RX_RST_BIT 1
`define UER_FCR_TX_RST_BIT 2
// interrupt mask bits
`define UER_IER_RX_BIT 0
`define UER_IER_TX_BIT 1
`define UER_IER_LS_BIT 2
`define UER_IER_MS_BIT 3

// gating masks for the enhanced bits
`define UER_IER_BASE_MASK 8'h0f
`define UER_ISR_BASE_MASK 8'hcf
`define UER_FCR_BASE_MASK 8'hcf
`define UER_MCR_BASE_MASK 8'h1f

// interrupt status source codes in bits 3:0
`define UER_ISR_NONE 4'h1
`define UER_ISR_LINE 4'h6
`define UER_ISR_RECEIVE_READY_N 4'h4
`define UER_ISR_TRANSMIT_READY_N 4'h2
`define UER_ISR_MODEM 4'h0

// reset values
`define UER_RST_ZERO 8'h00
`define UER_RST_ISR 8'h01
`define UER_RST_SUMSEL 1'b1

// identity codes, values arbitrary
`define UER_REVISION_DEFAULT 8'h01
`define UER_DEVICE_ID_DEFAULT 8'h5a

`endif

// *** uer_pkg.sv ***
package uer_pkg;

  // which register bank the address lines currently see
  typedef enum logic [1:0] {
    UER_BANK_STD = 2'b00,
    UER_BANK_DIV = 2'b01,
    UER_BANK_ENH = 2'b10
  } uer_bank_t;

  typedef logic [7:0] uer_byte_t;

endpackage : uer_pkg

// *** uer_pin_sync.sv ***
`timescale 1ns/100ps
`default_nettype none

// three-stage pin synchroniser; the level moves only when stages two and
// three agree, so a single metastable sample cannot glitch the output
module uer_pin_sync
  import uer_pkg::*;
#(
  parameter logic RESET_LEVEL = 1'b1
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic pin_i,
  output logic level_o
);

  logic meta_reg; // first stage, read only by the second
  logic mid_reg;
  logic last_reg;

  // capture chain
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      meta_reg <= RESET_LEVEL;
      mid_reg <= RESET_LEVEL;
      last_reg <= RESET_LEVEL;
    end else begin
      meta_reg <= pin_i;
      mid_reg <= meta_reg;
      last_reg <= mid_reg;
    end
  end

  // accept a new level once the two settled stages agree
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      level_o <= RESET_LEVEL;
    end else if (mid_reg == last_reg) begin
      level_o <= last_reg;
    end
  end

endmodule : uer_pin_sync

`default_nettype wire

// *** uer_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none

// host processor in the far side's place; drives just after an edge
module uer_host_model (
  input wire logic mclk_i,
  input wire logic [7:0] rdata_i,
  output logic [2:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  // idle bus at time zero
  initial begin
    addr_o = 3'h0;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  // one write pulse; released lines show the inverse so no stale match
  task automatic write_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge mclk_i);
    wr_o <= 1'b0;
    wdata_o <= ~d;
    addr_o <= ~a;
  endtask : write_reg

  // one read pulse; answer stands from the taking edge and is sampled one edge later
  task automatic read_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge mclk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    @(posedge mclk_i);
    #1;
    d = rdata_i;
  endtask : read_reg
endmodule : uer_host_model

`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import uer_pkg::*;
  localparam logic [7:0] REV = 8'h3c; // arbitrary value
  localparam logic [7:0] DID = 8'h96; // arbitrary value
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, interrupt_status, fifo_control, interrupt_mask, modem_control, lcr_o, fifo_trigger_level_write, feature_control, enhanced_function;
  logic [7:0] lvl = 8'h00;
  logic [7:0] txd; // transmit byte handed to the data path
  logic txw, rxr, rff, tff; // one-cycle data-path strobes
  logic [15:0] pulses = 16'h0000; // strobe counts, one nibble each
  logic [7:0] x1, x2, f1, f2;
  logic wr, rd, sel_n = 1'b1, loaded = 1'b0, lerr = 1'b0, txe = 1'b0;
  logic mdelta = 1'b0, dr, irq;
  logic [3:0] rr_n = 4'hf, tr_n = 4'hf;
  logic [1:0] enh = 2'b00;
  logic [15:0] div;
  int bad_count = 0;
  int tests_run = 0;

  // 10 MHz clock
  always #50 mclk_i = ~mclk_i;

  uer_host_model i_host (.mclk_i(mclk_i), .rdata_i(rdata), .addr_o(addr),
    .wdata_o(wdata), .wr_o(wr), .rd_o(rd));

  uer_register_map #(.REVISION(REV), .DEVICE_ID(DID)) i_dut (
    .mclk_i(mclk_i), .reset_i(reset_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .summary_select_n_i(sel_n),
    .receive_ready_n_i(rr_n), .transmit_ready_n_i(tr_n),
    .receive_holding_i(8'h6b), .rx_fifo_level_i(lvl),
    .rx_char_loaded_i(loaded), .line_status_upper_i(7'h30),
    .line_error_i(lerr), .tx_empty_i(txe), .modem_status_i(8'hc3),
    .modem_delta_i(mdelta), .enh_status_i(enh), .rdata_o(rdata),
    .rx_read_o(rxr), .tx_write_o(txw), .tx_data_o(txd),
    .rx_fifo_reset_o(rff), .tx_fifo_reset_o(tff), .divisor_o(div),
    .line_control_o(lcr_o),
    .interrupt_mask_o(interrupt_mask), .fifo_control_o(fifo_control), .modem_control_o(modem_control),
    .feature_control_o(feature_control), .enhanced_function_o(enhanced_function),
    .trigger_level_o(fifo_trigger_level_write), .resume_char_first_o(x1),
    .resume_char_second_o(x2), .pause_char_first_o(f1),
    .pause_char_second_o(f2), .interrupt_status_o(interrupt_status),
    .data_ready_o(dr), .int_o(irq));

  // count each strobe once per cycle that it stands
  always @(posedge mclk_i) begin
    pulses[3:0] <= pulses[3:0] + {3'h0, txw};
    pulses[7:4] <= pulses[7:4] + {3'h0, rxr};
    pulses[11:8] <= pulses[11:8] + {3'h0, rff};
    pulses[15:12] <= pulses[15:12] + {3'h0, tff};
  end

  // compare and count; 16 bits covers the divisor pair
  task automatic check(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    i_host.write_reg(a, d);
    #1; // the written register updates at the taking edge
  endtask : wr_reg

  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] d;
    i_host.read_reg(a, d);
    check("read data", {8'h00, d}, {8'h00, exp});
  endtask : rd_chk

  // let registered outputs and source flops settle
  task automatic settle(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : settle

  // divisor bank, identity read-back while both latches are zero
  task automatic t_divisor();
    wr_reg(3'h3, 8'h80);
    rd_chk(3'h0, REV);
    rd_chk(3'h1, DID);
    wr_reg(3'h0, 8'h12);
    rd_chk(3'h0, 8'h12);
    rd_chk(3'h1, 8'h00);
    wr_reg(3'h1, 8'h34);
    wr_reg(3'h0, 8'h00);
    // low latch zero but high not: latches still show
    rd_chk(3'h0, 8'h00);
    rd_chk(3'h1, 8'h34);
    check("divisor", div, 16'h3400);
  endtask : t_divisor

  // key bank: every read/write place, trigger write and level read
  task automatic t_keybank();
    logic [7:0] got [8];
    wr_reg(3'h3, 8'hbf);
    for (int a = 1; a < 8; a++) begin
      if (a != 3) begin
        wr_reg(a[2:0], 8'h5a ^ 8'(a));
      end
    end
    got = '{8'h00, feature_control, enhanced_function, 8'h00, x1, x2, f1, f2};
    for (int a = 1; a < 8; a++) begin
      if (a != 3) begin
        check("key out", {8'h00, got[a]}, {8'h00, 8'h5a ^ 8'(a)});
        rd_chk(a[2:0], 8'h5a ^ 8'(a));
      end
    end
    wr_reg(3'h1, 8'hb6);
    check("feature", {8'h00, feature_control}, 16'h00b6);
    wr_reg(3'h0, 8'h04);
    check("trigger", {8'h00, fifo_trigger_level_write}, 16'h0004);
    @(posedge mclk_i);
    lvl <= 8'h2e;
    rd_chk(3'h0, 8'h2e);
    wr_reg(3'h2, 8'h00);
    check("enh func", {8'h00, enhanced_function}, 16'h0000);
  endtask : t_keybank

  // enhanced bits gated until the unlock bit is set
  task automatic t_unlock(input logic on, input logic [7:0] e_ier,
                          input logic [7:0] e_isr);
    @(posedge mclk_i);
    enh <= 2'b11;
    wr_reg(3'h3, 8'hbf);
    wr_reg(3'h2, {3'b000, on, 4'h0});
    wr_reg(3'h3, 8'h03);
    wr_reg(3'h1, 8'hf0);
    wr_reg(3'h4, 8'he0);
    settle(3);
    check("mask", {8'h00, interrupt_mask}, {8'h00, e_ier});
    check("modem ctl", {8'h00, modem_control}, {8'h00, e_ier & 8'he0});
    check("status", {8'h00, interrupt_status}, {8'h00, e_isr});
  endtask : t_unlock

  // mask gating, priority, trigger set and clear
  task automatic t_irq();
    logic [7:0] m [5] = '{8'h08, 8'h0a, 8'h0b, 8'h0f, 8'h00};
    logic [7:0] e [5] = '{8'hc0, 8'hc2, 8'hc4, 8'hc6, 8'hc1};
    wr_reg(3'h2, 8'h01);
    wr_reg(3'h1, 8'h01);
    @(posedge mclk_i);
    lvl <= 8'h03;
    settle(3);
    check("rx below", {7'h00, irq, interrupt_status}, 16'h00c1);
    @(posedge mclk_i);
    lvl <= 8'h04;
    settle(3);
    check("rx at trig", {7'h00, irq, interrupt_status}, 16'h01c4);
    @(posedge mclk_i);
    lvl <= 8'h03;
    settle(3);
    check("rx drop", {7'h00, irq, interrupt_status}, 16'h00c1);
    @(posedge mclk_i);
    lvl <= 8'h04;
    lerr <= 1'b1;
    txe <= 1'b1;
    mdelta <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      wr_reg(3'h1, m[i]);
      settle(3);
      check("gated", {8'h00, interrupt_status}, {8'h00, e[i]});
    end
    @(posedge mclk_i);
    lerr <= 1'b0;
    txe <= 1'b0;
    mdelta <= 1'b0;
    wr_reg(3'h2, 8'h00);
    wr_reg(3'h1, 8'h01);
    @(posedge mclk_i);
    lvl <= 8'h03;
    settle(3);
    // fifo off: any data is enough
    check("no fifo", {7'h00, irq, interrupt_status}, 16'h0104);
    @(posedge mclk_i);
    lvl <= 8'h00;
  endtask : t_irq

  // data ready flag and a write to a status place
  task automatic t_ready();
    @(posedge mclk_i);
    lvl <= 8'h01;
    loaded <= 1'b1;
    @(posedge mclk_i);
    loaded <= 1'b0;
    settle(2);
    check("ready", {15'h0, dr}, 16'h0001);
    wr_reg(3'h5, 8'h00);
    rd_chk(3'h5, 8'h61);
    rd_chk(3'h1, 8'h01);
    check("lcr kept", {8'h00, lcr_o}, 16'h0003);
    @(posedge mclk_i);
    lvl <= 8'h00;
    settle(3);
    check("empty", {15'h0, dr}, 16'h0000);
  endtask : t_ready

  // data-path strobes and fifo control from the standard bank
  task automatic t_strobe();
    wr_reg(3'h0, 8'h9c);
    check("tx data", {8'h00, txd}, 16'h009c);
    rd_chk(3'h0, 8'h6b);
    // reset bits only act with the enable bit; bits 5:4 stay locked
    wr_reg(3'h2, 8'h37);
    settle(2);
    check("fifo ctl", {8'h00, fifo_control}, 16'h0001);
    wr_reg(3'h2, 8'h02);
    settle(2);
    check("fifo off", {8'h00, fifo_control}, 16'h0000);
    check("strobes", pulses, 16'h1111);
  endtask : t_strobe

  // summary select pin, address ignored
  task automatic t_summary();
    @(posedge mclk_i);
    sel_n <= 1'b0;
    rr_n <= 4'ha;
    tr_n <= 4'h5;
    settle(6);
    rd_chk(3'h3, 8'ha5);
    rd_chk(3'h6, 8'ha5);
    @(posedge mclk_i);
    sel_n <= 1'b1;
    settle(6);
    rd_chk(3'h3, 8'h03);
  endtask : t_summary

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  // main sequence
  initial begin
    repeat (20) @(posedge mclk_i);
    reset_i <= 1'b0;
    settle(1);
    check("reset isr", {7'h00, irq, interrupt_status}, 16'h0001);
    check("reset div", div, 16'h0000);
    t_divisor();
    t_keybank();
    t_unlock(1'b0, 8'h00, 8'h01);
    t_unlock(1'b1, 8'hf0, 8'h31);
    t_unlock(1'b0, 8'h00, 8'h01);
    @(posedge mclk_i);
    enh <= 2'b00;
    wr_reg(3'h3, 8'hbf);
    wr_reg(3'h0, 8'h04);
    wr_reg(3'h3, 8'h03);
    t_irq();
    t_ready();
    t_strobe();
    t_summary();
    end_sim();
  end
endmodule : tb_top

`default_nettype wire
